// [inc/brg_pkg.sv]
// Package: register map, fields and divider constants of the baud rate generator
package brg_pkg;
  localparam logic [31:0] BRG_RATE_CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] BRG_STATUS_ADDR = 32'h0000_0004;
  localparam int BRG_RATE_LSB = 0;
  localparam int BRG_RATE_MSB = 2;
  localparam int BRG_PRE_LSB = 4;
  localparam int BRG_PRE_MSB = 5;
  localparam logic [7:0] BRG_CTRL_RESET = 8'h00;
  localparam logic [7:0] BRG_CTRL_MASK = 8'h37;
  localparam logic [5:0] BRG_BASE_DIV = 6'h3f;
  // Prescale counter limits: the divisor minus one
  localparam logic [3:0] BRG_PRE_LIMIT_00 = 4'h0;
  localparam logic [3:0] BRG_PRE_LIMIT_01 = 4'h2;
  localparam logic [3:0] BRG_PRE_LIMIT_10 = 4'h3;
  localparam logic [3:0] BRG_PRE_LIMIT_11 = 4'hc;
  localparam logic [1:0] BRG_HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    BRG_IDLE = 2'b01,
    BRG_DATA = 2'b10
  } brg_phase_t;
endpackage

// [verilog/brg_prescale.sv]
// Prescaler stage: divides a tick stream by 1, 3, 4 or 13
`timescale 1ns/1ps
module brg_prescale
  import brg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick_in,
  input wire logic [1:0] prescale_select,
  output logic tick_out
);
  logic [3:0] count;
  logic [3:0] next_count;
  logic next_tick;
  logic [3:0] limit;

  always_comb begin
    unique case (prescale_select)
      2'b00: limit = BRG_PRE_LIMIT_00;
      2'b01: limit = BRG_PRE_LIMIT_01;
      2'b10: limit = BRG_PRE_LIMIT_10;
      2'b11: limit = BRG_PRE_LIMIT_11;
    endcase
    next_count = count;
    next_tick = 1'b0;
    if (tick_in) begin
      if (count >= limit) begin
        next_count = 4'h0;
        next_tick = 1'b1;
      end else begin
        next_count = count + 4'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 4'h0;
      tick_out <= 1'b0;
    end else begin
      count <= next_count;
      tick_out <= next_tick;
    end
  end
endmodule // brg_prescale

// [verilog/brg_top.sv]
// Baud rate generator of the serial interface with an AHB-Lite register slave
`timescale 1ns/1ps
module brg_top
  import brg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic bit_rate_enable,
  output logic tx_rate_enable,
  output logic rx_rate_enable
);
  logic [7:0] serial_rate_control;
  logic [7:0] next_serial_rate_control;
  brg_phase_t phase;
  brg_phase_t next_phase;
  logic wr_pend;
  logic next_wr_pend;
  logic [31:0] addr_q;
  logic [31:0] next_addr_q;
  logic [31:0] next_hrdata;
  logic [5:0] base_count;
  logic [5:0] next_base_count;
  logic base_tick;
  logic next_base_tick;
  logic pre_tick;
  logic [6:0] rate_count;
  logic [6:0] next_rate_count;
  logic next_rate_tick;
  logic rate_tick;
  logic [2:0] rate_divisor_select;
  logic [1:0] prescale_select;
  logic [6:0] rate_limit;
  logic take;

  assign rate_divisor_select = serial_rate_control[BRG_RATE_MSB:BRG_RATE_LSB];
  assign prescale_select = serial_rate_control[BRG_PRE_MSB:BRG_PRE_LSB];
  assign take = hsel && hready && (htrans == BRG_HTRANS_NONSEQ);

  // Zero wait-state slave; unmapped addresses read zero and ignore writes
  always_comb begin
    next_phase = take ? BRG_DATA : BRG_IDLE;
    next_wr_pend = take && hwrite;
    next_addr_q = take ? haddr : addr_q;
    next_serial_rate_control = serial_rate_control;
    if ((phase == BRG_DATA) && wr_pend && (addr_q == BRG_RATE_CTRL_ADDR)) begin
      next_serial_rate_control = hwdata[7:0] & BRG_CTRL_MASK;
    end
    next_hrdata = 32'h0000_0000;
    if (take && !hwrite) begin
      if (haddr == BRG_RATE_CTRL_ADDR) begin
        next_hrdata = {24'h00_0000, serial_rate_control};
      end else if (haddr == BRG_STATUS_ADDR) begin
        next_hrdata = {25'h000_0000, rate_count};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_rate_control <= BRG_CTRL_RESET;
      phase <= BRG_IDLE;
      wr_pend <= 1'b0;
      addr_q <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      serial_rate_control <= next_serial_rate_control;
      phase <= next_phase;
      wr_pend <= next_wr_pend;
      addr_q <= next_addr_q;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Fixed divide by 64 ahead of the selectable stages
  always_comb begin
    next_base_count = base_count + 6'h01;
    next_base_tick = (base_count == BRG_BASE_DIV);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_count <= 6'h00;
      base_tick <= 1'b0;
    end else begin
      base_count <= next_base_count;
      base_tick <= next_base_tick;
    end
  end

  brg_prescale u_prescale (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick_in(base_tick),
    .prescale_select(prescale_select),
    .tick_out(pre_tick)
  );

  // Limit is read live: a new code applies from the next count (no restart)
  always_comb begin
    rate_limit = 7'((8'h01 << rate_divisor_select) - 8'h01);
    next_rate_count = rate_count;
    next_rate_tick = 1'b0;
    if (pre_tick) begin
      if (rate_count >= rate_limit) begin
        next_rate_count = 7'h00;
        next_rate_tick = 1'b1;
      end else begin
        next_rate_count = rate_count + 7'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_count <= 7'h00;
      rate_tick <= 1'b0;
      bit_rate_enable <= 1'b0;
      tx_rate_enable <= 1'b0;
      rx_rate_enable <= 1'b0;
    end else begin
      rate_count <= next_rate_count;
      rate_tick <= next_rate_tick;
      bit_rate_enable <= next_rate_tick;
      tx_rate_enable <= next_rate_tick;
      rx_rate_enable <= next_rate_tick;
    end
  end

  // Enable spacing for the checks below; saturates so a stuck divider cannot wrap
  logic [16:0] gap;
  logic [16:0] next_gap;
  logic cfg_hit;
  logic next_cfg_hit;
  logic [3:0] pre_limit;
  logic [16:0] period_exp;

  // A period that saw reset or a new setting is not a clean sample
  always_comb begin
    next_gap = (gap == 17'h1_ffff) ? gap : gap + 17'h0_0001;
    if (bit_rate_enable) begin
      next_gap = 17'h0_0001;
    end
    next_cfg_hit = bit_rate_enable ? 1'b0 : cfg_hit;
    if (next_serial_rate_control != serial_rate_control) begin
      next_cfg_hit = 1'b1;
    end
    unique case (prescale_select)
      2'b00: pre_limit = BRG_PRE_LIMIT_00;
      2'b01: pre_limit = BRG_PRE_LIMIT_01;
      2'b10: pre_limit = BRG_PRE_LIMIT_10;
      2'b11: pre_limit = BRG_PRE_LIMIT_11;
    endcase
    period_exp = ((17'(pre_limit) + 17'h0_0001) * (17'(BRG_BASE_DIV) + 17'h0_0001))
      << rate_divisor_select;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap <= 17'h0_0000;
      cfg_hit <= 1'b1;
    end else begin
      gap <= next_gap;
      cfg_hit <= next_cfg_hit;
    end
  end

  sequence s_pre_then_enable;
    pre_tick ##1 bit_rate_enable;
  endsequence

  a_shared_enables: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_rate_enable == rx_rate_enable && tx_rate_enable == bit_rate_enable)
    else $error("tx and rx rate enables differ");
  a_enable_single: assert property (@(posedge hclk) disable iff (!hresetn)
    bit_rate_enable |=> !bit_rate_enable)
    else $error("rate enable longer than one cycle");
  a_base_period: assert property (@(posedge hclk) disable iff (!hresetn)
    base_tick |=> !base_tick [*8])
    else $error("base tick too frequent");
  a_prescale_one: assert property (@(posedge hclk) disable iff (!hresetn)
    (base_tick && prescale_select == 2'b00 && $stable(prescale_select)) |=> pre_tick)
    else $error("prescale 1 missed tick");
  a_rate_one: assert property (@(posedge hclk) disable iff (!hresetn)
    (pre_tick && rate_divisor_select == 3'h0) |=> bit_rate_enable)
    else $error("rate divisor 1 missed enable");
  a_reset_fields: assert property (@(posedge hclk)
    $rose(hresetn) |-> serial_rate_control == 8'h00)
    else $error("control fields not cleared");
  a_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend && addr_q == BRG_RATE_CTRL_ADDR) |=>
      serial_rate_control[2:0] == $past(hwdata[2:0]))
    else $error("rate field write lost");
  a_default_period: assert property (@(posedge hclk) disable iff (!hresetn)
    (bit_rate_enable && serial_rate_control == BRG_CTRL_RESET && !cfg_hit) |->
      gap == 17'h0_0040)
    else $error("default bit period not 64 cycles");
  a_prescale_13: assert property (@(posedge hclk) disable iff (!hresetn)
    (pre_tick && prescale_select == 2'b11) |=> !pre_tick [*8])
    else $error("prescale 13 ticks too early");
  // Every code pair, once a full period has run on a steady setting
  a_any_period: assert property (@(posedge hclk) disable iff (!hresetn)
    (bit_rate_enable && !cfg_hit) |-> gap == period_exp)
    else $error("bit period differs from divisor product");
  // Fastest chain: base tick, then prescale tick, then enable, one cycle apart
  a_fast_chain: assert property (@(posedge hclk) disable iff (!hresetn)
    (base_tick && serial_rate_control == BRG_CTRL_RESET && !wr_pend) |=> s_pre_then_enable)
    else $error("fastest setting chain broken");
endmodule // brg_top

// [verification/brg_top_test.sv]
// Testbench: register access and rate enable periods of the baud rate generator
`timescale 1ns/1ps
module brg_top_test;
  import brg_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, bit_rate_enable, tx_rate_enable, rx_rate_enable;
  logic [31:0] hrdata, rd;
  int failures = 0;
  int checks_done = 0;
  int per;
  int pdv[4] = '{1, 3, 4, 13};
  always #5 hclk = ~hclk;
  // Single slave on the bus, so its ready closes the loop
  assign hready = hreadyout;
  brg_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .bit_rate_enable(bit_rate_enable),
    .tx_rate_enable(tx_rate_enable), .rx_rate_enable(rx_rate_enable));
  task stop_test;
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait on an edge where ready is sampled high
  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      stop_test();
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= BRG_HTRANS_NONSEQ;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // Skip two pulses so a period cut by the write is not measured
  task measure;
    per = 0;
    repeat (3) begin
      per = 0;
      do begin
        @(posedge hclk);
        per++;
      end while (bit_rate_enable !== 1'b1 && per < 20000);
      if (bit_rate_enable !== 1'b1) begin
        failures++;
        stop_test();
      end
      chk("tx_rate_enable", 32'h1, {31'h0, tx_rate_enable});
      chk("rx_rate_enable", 32'h1, {31'h0, rx_rate_enable});
    end
  endtask
  task setp(input logic [7:0] v, input int exp);
    ahb(1'b1, BRG_RATE_CTRL_ADDR, {24'h0, v});
    ahb(1'b0, BRG_RATE_CTRL_ADDR, 32'h0);
    chk("serial_rate_control", {24'h0, v & BRG_CTRL_MASK}, rd);
    measure();
    chk("period", exp, per);
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, BRG_RATE_CTRL_ADDR, 32'h0);
    chk("serial_rate_control", 32'h0, rd);
    measure();
    chk("period", 32'h40, per);
    $display("Test reset done");
    ahb(1'b1, BRG_RATE_CTRL_ADDR, 32'hffff_ffff);
    ahb(1'b0, BRG_RATE_CTRL_ADDR, 32'h0);
    chk("serial_rate_control", 32'h37, rd);
    ahb(1'b1, 32'h0000_0008, 32'h0000_0015);
    ahb(1'b0, 32'h0000_0008, 32'h0);
    chk("unmapped", 32'h0, rd);
    ahb(1'b0, BRG_RATE_CTRL_ADDR, 32'h0);
    chk("serial_rate_control", 32'h37, rd);
    $display("Test register access done");
    for (int i = 0; i < 4; i++) begin
      setp(8'(i << 4), 64 * pdv[i]);
    end
    // Rate field is zero here, so the rate counter rests at zero
    ahb(1'b0, BRG_STATUS_ADDR, 32'h0);
    chk("rate_count", 32'h0, rd);
    $display("Test prescale codes done");
    for (int i = 0; i < 8; i++) begin
      setp(8'(i), 64 << i);
    end
    setp(8'h31, 64 * 13 * 2);
    $display("Test rate codes done");
    stop_test();
  end
endmodule // brg_top_test
